// ---- dv/cmt_host.sv ----
// Host processor model for the plain strobe register port.
// Assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module cmt_host (
  input wire logic clk_sys,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Released data is inverted so a stale bus value is never mistaken for a fresh one.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : wr_reg

  // Two writes with no gap: the strobe stays high across both cycles.
  task automatic wr_pair(input logic [3:0] a, input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= lo;
    @(posedge clk_sys);
    wdata <= hi;
    @(posedge clk_sys);
    wr <= 1'b0;
    wdata <= ~hi;
  endtask : wr_pair

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : cmt_host
`default_nettype wire

// ---- dv/cmt_top_bench.sv ----
// Self-checking bench for the master mode, status, alarm and 24-hour clock block.
// Assumes the host model drives the register port; the bench drives the side inputs.
`timescale 1ns/10ps
`default_nettype none
module cmt_top_bench;
  import cmt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] rv;
  logic wr;
  logic rd;
  logic c1_out;
  logic c2_out;
  logic f_out;
  logic tick = 1'b0;
  logic oe = 1'b1;
  logic [4:0] raw = 5'b1_0100;
  logic [4:0] irq = 5'b1_0110;
  logic [4:0] pins = 5'h00;
  logic [3:0] tops [1:3] = '{4'h4, 4'h5, 4'h9};
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;
  int cnt;

  always #12.5 clk_sys = ~clk_sys;

  cmt_host host (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  cmt_top dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .counter_out_raw(raw), .counter_irq_state(irq),
    .output_enable_flag(oe), .counter1_tick(tick), .source_pin(pins), .gate_pin(pins),
    .counter1_out(c1_out), .counter2_out(c2_out), .freq_out(f_out));

  function automatic logic [15:0] stat(input logic ptr, input logic [1:0] outs,
    input logic [1:0] cmp);
    return {2'b00, oe, irq, cmp, raw[4:2], outs, ptr};
  endfunction : stat

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse;
    @(posedge clk_sys);
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic toggles(input int len, output int n);
    logic prev;
    repeat (3) @(posedge clk_sys);
    #1;
    prev = f_out;
    n = 0;
    repeat (len) begin
      @(posedge clk_sys);
      #1;
      if (f_out !== prev) n++;
      prev = f_out;
    end
  endtask : toggles

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // The ceiling is more than ten times the length of the whole sequence.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    host.rd_reg(CMT_ADDR_STATUS, rv);
    chk(rv, stat(1'b0, 2'b00, 2'b00));
    host.wr_reg(CMT_ADDR_MODE, 16'h0000);
    host.rd_reg(CMT_ADDR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0001);
    host.wr_reg(CMT_ADDR_MODE, 16'h0020);
    host.rd_reg(CMT_ADDR_MODE, rv);
    chk(rv, 16'h2000);
    host.wr_reg(CMT_ADDR_MODE, 16'h4000);
    host.wr_reg(CMT_ADDR_ALARM1, 16'h0034);
    host.rd_reg(CMT_ADDR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0000);
    host.wr_reg(CMT_ADDR_CMD, 16'h0002);
    host.rd_reg(CMT_ADDR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0001);
    host.wr_reg(CMT_ADDR_CMD, 16'h0001);
    host.wr_reg(CMT_ADDR_MODE, 16'h0000);
    host.wr_reg(CMT_ADDR_CMD, 16'h0002);
    host.wr_reg(CMT_ADDR_MODE, 16'h0020);
    host.wr_reg(CMT_ADDR_CMD, 16'h0001);
    host.rd_reg(CMT_ADDR_MODE, rv);
    chk(rv, 16'h2000);
    host.wr_reg(CMT_ADDR_EXT, 16'hffff);
    host.rd_reg(CMT_ADDR_EXT, rv);
    chk(rv, 16'h0007);
    host.wr_reg(4'hc, 16'hffff);
    host.rd_reg(4'hc, rv);
    chk(rv, 16'h0000);
    host.wr_reg(CMT_ADDR_EXT, 16'h0000);
    host.wr_reg(CMT_ADDR_MODE, 16'h0000);
    host.wr_pair(CMT_ADDR_MODE, 16'h00f0, 16'h0000);
    host.rd_reg(CMT_ADDR_MODE, rv);
    chk(rv, 16'h00f0);
    host.rd_reg(CMT_ADDR_MODE, rv);
    chk(rv, 16'h0000);
    host.wr_pair(CMT_ADDR_MODE, 16'h00f0, 16'h0020);
    host.rd_reg(CMT_ADDR_MODE, rv);
    chk(rv, 16'h20f0);
    $display("test bus and pointer done");

    host.wr_reg(CMT_ADDR_CNT1, 16'h1234);
    host.wr_reg(CMT_ADDR_ALARM1, 16'h1234);
    host.wr_reg(CMT_ADDR_CNT2, 16'h0505);
    host.wr_reg(CMT_ADDR_ALARM2, 16'h0505);
    for (k = 0; k < 4; k++) begin
      host.wr_reg(CMT_ADDR_MODE, 16'h2000 | (16'(k) << 2));
      repeat (3) @(posedge clk_sys);
      chk({14'h0000, c2_out, c1_out}, 16'(k));
      host.rd_reg(CMT_ADDR_STATUS, rv);
      chk(rv, stat(1'b0, 2'(k), 2'(k)));
    end
    host.wr_reg(CMT_ADDR_ALARM1, 16'h1235);
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, c1_out}, 16'h0000);
    host.wr_reg(CMT_ADDR_MODE, 16'h200d);
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, c2_out}, 16'h0000);
    host.wr_reg(CMT_ADDR_ALARM1, 16'h1234);
    repeat (3) @(posedge clk_sys);
    chk({14'h0000, c2_out, c1_out}, 16'h0003);
    $display("test comparators done");

    for (k = 1; k < 4; k++) begin
      host.wr_reg(CMT_ADDR_MODE, 16'h2000 | 16'(k));
      host.wr_reg(CMT_ADDR_CNT1, {12'h000, tops[k]});
      pulse();
      host.wr_reg(CMT_ADDR_CMD, 16'h0004);
      host.rd_reg(CMT_ADDR_CNT1, rv);
      chk(rv, 16'h0010);
    end
    host.wr_reg(CMT_ADDR_CNT1, 16'h5999);
    host.wr_reg(CMT_ADDR_CNT2, 16'h2359);
    pulse();
    host.wr_reg(CMT_ADDR_CMD, 16'h000c);
    host.rd_reg(CMT_ADDR_CNT1, rv);
    chk(rv, 16'h0000);
    host.rd_reg(CMT_ADDR_CNT2, rv);
    chk(rv, 16'h0000);
    $display("test time of day done");

    host.wr_reg(CMT_ADDR_MODE, 16'h2100);
    toggles(16, cnt);
    chk(16'(cnt), 16'h0010);
    host.wr_reg(CMT_ADDR_EXT, 16'h0002);
    toggles(16, cnt);
    chk(16'(cnt), 16'h0004);
    host.wr_reg(CMT_ADDR_MODE, 16'h3100);
    toggles(16, cnt);
    chk({15'h0000, f_out} | 16'(cnt), 16'h0000);
    host.wr_reg(CMT_ADDR_EXT, 16'h0000);
    host.wr_reg(CMT_ADDR_MODE, 16'h21c0);
    toggles(16, cnt);
    chk(16'(cnt), 16'h0001);
    host.wr_reg(CMT_ADDR_MODE, 16'ha1c0);
    toggles(20, cnt);
    chk(16'(cnt), 16'h0002);
    $display("test frequency output done");
    tally_and_finish();
  end
endmodule : cmt_top_bench
`default_nettype wire

// ---- src/cmt_freq_out.sv ----
// Frequency output: source selection, programmable divider and gate.
// Assumes pin inputs are synchronous; an event is any edge of the chosen pin.
`timescale 1ns/10ps
`default_nettype none
module cmt_freq_out (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] freq_tick,
  input wire logic [4:0] source_pin,
  input wire logic [4:0] gate_pin,
  input wire logic counter1_level,
  input wire logic counter2_level,
  input wire logic [4:0] source_code,
  input wire logic [3:0] divider_basic,
  input wire logic [1:0] divider_ext,
  input wire logic gate_off,
  output logic freq_out
);
  import cmt_pkg::*;

  logic [11:0] pin_prev;
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic next_out;
  logic [11:0] pin_edge;
  logic event_hit;
  logic [8:0] factor;

  // Basic field gives 1 to 16; the extension multiplies it by 1, 4, 8 or 16.
  function automatic logic [8:0] div_factor(input logic [3:0] b, input logic [1:0] e);
    logic [8:0] base;
    base = (b == 4'h0) ? 9'h010 : {5'h00, b};
    unique case (e)
      2'h0: div_factor = base;
      2'h1: div_factor = 9'(base << 2);
      2'h2: div_factor = 9'(base << 3);
      2'h3: div_factor = 9'(base << 4);
    endcase
  endfunction : div_factor

  always_comb begin
    pin_edge = {counter2_level, counter1_level, gate_pin, source_pin} ^ pin_prev;
    factor = div_factor(divider_basic, divider_ext);
    event_hit = 1'b0;
    if (source_code == CMT_SRC_F1) begin
      event_hit = freq_tick[0];
    end else if (source_code < CMT_SRC_GATE_LO) begin
      event_hit = pin_edge[3'(source_code - CMT_SRC_PIN_LO)];
    end else if (source_code < CMT_SRC_INT_LO) begin
      event_hit = pin_edge[4'(source_code - CMT_SRC_PIN_LO)];
    end else if (source_code < CMT_SRC_CNT1) begin
      event_hit = freq_tick[3'(source_code - CMT_SRC_INT_LO)];
    end else if (source_code <= CMT_SRC_CNT2) begin
      event_hit = pin_edge[4'(source_code - CMT_SRC_CNT1) + 4'ha];
    end
    next_cnt = cnt;
    next_out = freq_out;
    if (gate_off) begin
      next_cnt = 9'h000;
      next_out = 1'b0;
    end else if (event_hit) begin
      if (cnt >= factor - 9'h001) begin
        next_cnt = 9'h000;
        next_out = !freq_out;
      end else begin
        next_cnt = cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    pin_prev <= rst ? 12'h000 : {counter2_level, counter1_level, gate_pin, source_pin};
    cnt <= rst ? 9'h000 : next_cnt;
    freq_out <= rst ? 1'b0 : next_out;
  end

endmodule : cmt_freq_out
`default_nettype wire

// ---- src/cmt_pkg.sv ----
// Shared constants for the counter master-mode and time-of-day block.
// Assumes a single 40 MHz system clock and a 4-bit register address.
package cmt_pkg;

  localparam int CMT_ADDR_W = 4;
  localparam int CMT_DATA_W = 16;

  // Register addresses.
  localparam logic [3:0] CMT_ADDR_STATUS = 4'h0;
  localparam logic [3:0] CMT_ADDR_MODE = 4'h1;
  localparam logic [3:0] CMT_ADDR_EXT = 4'h2;
  localparam logic [3:0] CMT_ADDR_ALARM1 = 4'h3;
  localparam logic [3:0] CMT_ADDR_ALARM2 = 4'h4;
  localparam logic [3:0] CMT_ADDR_CNT1 = 4'h5;
  localparam logic [3:0] CMT_ADDR_CNT2 = 4'h6;
  localparam logic [3:0] CMT_ADDR_CMD = 4'h7;

  // Reset values.
  localparam logic [15:0] CMT_MODE_RST = 16'h0000;
  localparam logic [15:0] CMT_EXT_RST = 16'h0000;
  localparam logic [15:0] CMT_WORD_RST = 16'h0000;

  // Fields of global_mode_control.
  localparam int CMT_MODE_TOD_LO = 0;
  localparam int CMT_MODE_ALARM_LO = 2;
  localparam int CMT_MODE_SRC_LO = 4;
  localparam int CMT_MODE_DIV_LO = 8;
  localparam int CMT_MODE_GATE = 12;
  localparam int CMT_MODE_BUS = 13;
  localparam int CMT_MODE_POINT = 14;
  localparam int CMT_MODE_SCALE = 15;

  // Fields of global_mode_extension.
  localparam int CMT_EXT_SRC = 0;
  localparam int CMT_EXT_DIV_LO = 1;

  // Bits of the command register.
  localparam int CMT_CMD_PTR_RESET = 0;
  localparam int CMT_CMD_PTR_STEP = 1;
  localparam int CMT_CMD_SNAP1 = 2;
  localparam int CMT_CMD_SNAP2 = 3;

  // Time-of-day codes, prescale tops and BCD limits.
  localparam logic [1:0] CMT_TOD_OFF = 2'h0;
  localparam logic [1:0] CMT_TOD_DIV5 = 2'h1;
  localparam logic [1:0] CMT_TOD_DIV6 = 2'h2;
  localparam logic [3:0] CMT_PRE_TOP5 = 4'h4;
  localparam logic [3:0] CMT_PRE_TOP6 = 4'h5;
  localparam logic [3:0] CMT_PRE_TOP10 = 4'h9;
  localparam logic [7:0] CMT_TENTH_TOP = 8'h09;
  localparam logic [7:0] CMT_SEC_TOP = 8'h59;
  localparam logic [7:0] CMT_HOUR_TOP = 8'h23;

  // Prescaler digit tops: binary steps of 16, decimal steps of 10.
  localparam logic [3:0] CMT_BIN_TOP = 4'hf;
  localparam logic [3:0] CMT_BCD_TOP = 4'h9;

  // Frequency output source codes.
  localparam logic [4:0] CMT_SRC_F1 = 5'h00;
  localparam logic [4:0] CMT_SRC_PIN_LO = 5'h01;
  localparam logic [4:0] CMT_SRC_GATE_LO = 5'h06;
  localparam logic [4:0] CMT_SRC_INT_LO = 5'h0b;
  localparam logic [4:0] CMT_SRC_CNT1 = 5'h10;
  localparam logic [4:0] CMT_SRC_CNT2 = 5'h11;

  typedef enum logic [1:0] {
    CMT_PTR_LOW = 2'b01,
    CMT_PTR_HIGH = 2'b10
  } cmt_ptr_e;

endpackage : cmt_pkg

// ---- src/cmt_prescale.sv ----
// Internal frequency prescaler giving the base tick and four divided tick streams.
// Assumes the system clock is the base frequency; ticks are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module cmt_prescale (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic radix_bcd,
  output logic [4:0] freq_tick
);
  import cmt_pkg::*;

  logic [3:0] digit [4];
  logic [3:0] next_digit [4];
  logic [3:0] top;

  always_comb begin
    top = radix_bcd ? CMT_BCD_TOP : CMT_BIN_TOP;
    freq_tick[0] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      freq_tick[i + 1] = freq_tick[i] && (digit[i] >= top);
      next_digit[i] = digit[i];
      if (freq_tick[i]) begin
        next_digit[i] = (digit[i] >= top) ? 4'h0 : digit[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      digit[i] <= rst ? 4'h0 : next_digit[i];
    end
  end

  a_radix_step: assert property (@(posedge clk_sys) disable iff (rst)
    (radix_bcd && freq_tick[1]) |=> (!freq_tick[1]) [*8] ##1 !freq_tick[1] ##1 freq_tick[1])
    else $error("decimal prescale stage does not tick every ten cycles");

endmodule : cmt_prescale
`default_nettype wire

// ---- src/cmt_top.sv ----
// Device-level master mode, status, alarm comparators and 24-hour clock.
// Assumes a host on a plain strobe port and per-counter logic outside the block.
//
// How it works
// - Status bit 0 byte pointer, bits 1-5 counter outputs, 6-7 comparators.
// - Nonzero time-of-day field links counters one and two as 24-hour clock.
// - Counter two holds BCD hours 0-23 high byte, minutes 0-59 low byte.
// - Counter one holds seconds, tenths, and a divide by 5, 6 or 10 prescale.
// - Counters one and two have 16-bit alarm comparators usable in any mode.
// - Enabled comparator drives counter output while value equals alarm value.
// - Comparator field 00 disables both, 01 one, 10 two, 11 both.
// - In time-of-day, counter two alarm output needs both comparators matching.
// - Frequency source field picks pins, gates or internal frequencies; 00000 first.
// - Extension source bit reaches sources beyond the basic sixteen.
// - Basic divider field divides the frequency output by 1 to 16.
// - Two extension divider bits extend division factors up to 256.
// - Gate bit disables the frequency output, held driven low.
// - Bus width bit picks 16-bit words or low-then-high byte transfers.
// - Pointer bit clear steps byte pointer automatically; set, only by command.
// - Scaling bit picks binary or decimal prescaler steps.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cmt_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [cmt_pkg::CMT_ADDR_W-1:0] addr,
  input wire logic [cmt_pkg::CMT_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [cmt_pkg::CMT_DATA_W-1:0] rdata,
  input wire logic [4:0] counter_out_raw,
  input wire logic [4:0] counter_irq_state,
  input wire logic output_enable_flag,
  input wire logic counter1_tick,
  input wire logic [4:0] source_pin,
  input wire logic [4:0] gate_pin,
  output logic counter1_out,
  output logic counter2_out,
  output logic freq_out
);
  import cmt_pkg::*;

  logic [15:0] global_mode_control;
  logic [15:0] global_mode_extension;
  logic [15:0] alarm1;
  logic [15:0] alarm2;
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [15:0] hold1;
  logic [15:0] hold2;
  logic [7:0] stage;
  cmt_ptr_e ptr;
  logic [15:0] next_mode;
  logic [15:0] next_ext;
  logic [15:0] next_alarm1;
  logic [15:0] next_alarm2;
  logic [15:0] next_cnt1;
  logic [15:0] next_cnt2;
  logic [15:0] next_hold1;
  logic [15:0] next_hold2;
  logic [7:0] next_stage;
  cmt_ptr_e next_ptr;
  logic [15:0] next_rdata;
  logic next_c1_out;
  logic next_c2_out;
  logic [1:0] tod_field;
  logic [1:0] alarm_enable_field;
  logic tod_on;
  logic wide;
  logic data_hit;
  logic commit;
  logic [15:0] wval;
  logic [15:0] sel_val;
  logic [15:0] status;
  logic alarm1_enable;
  logic alarm2_enable;
  logic alarm1_match_state;
  logic alarm2_match_state;
  logic [3:0] pre_top;
  logic [8:0] sec_step;
  logic [8:0] min_step;
  logic [8:0] hour_step;
  logic [8:0] tenth_step;
  logic [4:0] freq_tick;

  // Registers that go through the byte pointer; status and command do not.
  function automatic logic is_data(input logic [3:0] a);
    is_data = (a == CMT_ADDR_MODE) || (a == CMT_ADDR_EXT) || (a == CMT_ADDR_ALARM1) ||
      (a == CMT_ADDR_ALARM2) || (a == CMT_ADDR_CNT1) || (a == CMT_ADDR_CNT2);
  endfunction : is_data

  // Two-digit BCD increment with wrap at top; bit 8 flags the wrap.
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
    if (v >= top) begin
      bcd_inc = 9'h000;
    end else if (v[3:0] >= 4'h9) begin
      bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    if (v >= top) begin
      bcd_inc[8] = 1'b1;
    end
  endfunction : bcd_inc

  cmt_prescale u_prescale (
    .clk_sys(clk_sys),
    .rst(rst),
    .radix_bcd(global_mode_control[CMT_MODE_SCALE]),
    .freq_tick(freq_tick)
  );

  cmt_freq_out u_freq_out (
    .clk_sys(clk_sys),
    .rst(rst),
    .freq_tick(freq_tick),
    .source_pin(source_pin),
    .gate_pin(gate_pin),
    .counter1_level(counter1_out),
    .counter2_level(counter2_out),
    .source_code({global_mode_extension[CMT_EXT_SRC], global_mode_control[7:4]}),
    .divider_basic(global_mode_control[11:8]),
    .divider_ext(global_mode_extension[2:1]),
    .gate_off(global_mode_control[CMT_MODE_GATE]),
    .freq_out(freq_out)
  );

  // Comparators and status word.
  always_comb begin
    tod_field = global_mode_control[CMT_MODE_TOD_LO +: 2];
    alarm_enable_field = global_mode_control[CMT_MODE_ALARM_LO +: 2];
    tod_on = (tod_field != CMT_TOD_OFF);
    alarm1_enable = alarm_enable_field[0];
    alarm2_enable = alarm_enable_field[1];
    alarm1_match_state = alarm1_enable && (cnt1 == alarm1);
    alarm2_match_state = alarm2_enable && (cnt2 == alarm2) &&
      (!tod_on || (cnt1 == alarm1));
    next_c1_out = alarm1_enable ? alarm1_match_state : counter_out_raw[0];
    next_c2_out = alarm2_enable ? alarm2_match_state : counter_out_raw[1];
    status = {2'b00, output_enable_flag, counter_irq_state,
      alarm2_match_state, alarm1_match_state, counter_out_raw[4:2], counter2_out,
      counter1_out, ptr == CMT_PTR_HIGH};
  end

  // Register port, byte pointer and time-of-day counting.
  always_comb begin
    next_mode = global_mode_control;
    next_ext = global_mode_extension;
    next_alarm1 = alarm1;
    next_alarm2 = alarm2;
    next_cnt1 = cnt1;
    next_cnt2 = cnt2;
    next_hold1 = hold1;
    next_hold2 = hold2;
    next_stage = stage;
    next_ptr = ptr;
    next_rdata = CMT_WORD_RST;
    wide = global_mode_control[CMT_MODE_BUS];
    data_hit = (wr || rd) && is_data(addr);
    wval = wide ? wdata : {wdata[7:0], stage};
    commit = wr && is_data(addr) && (wide || ptr == CMT_PTR_HIGH);
    if (wr && is_data(addr) && !wide && ptr == CMT_PTR_LOW) begin
      next_stage = wdata[7:0];
    end
    unique case (ptr)
      CMT_PTR_LOW: begin
        if (data_hit && !wide && !global_mode_control[CMT_MODE_POINT]) begin
          next_ptr = CMT_PTR_HIGH;
        end
      end
      CMT_PTR_HIGH: begin
        if (data_hit && !wide && !global_mode_control[CMT_MODE_POINT]) begin
          next_ptr = CMT_PTR_LOW;
        end
      end
      default: next_ptr = CMT_PTR_LOW;
    endcase
    if (wr && addr == CMT_ADDR_CMD) begin
      if (wdata[CMT_CMD_PTR_STEP]) begin
        next_ptr = (ptr == CMT_PTR_HIGH) ? CMT_PTR_LOW : CMT_PTR_HIGH;
      end
      if (wdata[CMT_CMD_PTR_RESET]) begin
        next_ptr = CMT_PTR_LOW;
      end
      if (wdata[CMT_CMD_SNAP1]) begin
        next_hold1 = cnt1;
      end
      if (wdata[CMT_CMD_SNAP2]) begin
        next_hold2 = cnt2;
      end
    end
    // The count runs on from the tick even while a snapshot is taken.
    unique case (tod_field)
      CMT_TOD_DIV5: pre_top = CMT_PRE_TOP5;
      CMT_TOD_DIV6: pre_top = CMT_PRE_TOP6;
      default: pre_top = CMT_PRE_TOP10;
    endcase
    tenth_step = bcd_inc({4'h0, cnt1[7:4]}, CMT_TENTH_TOP);
    sec_step = bcd_inc(cnt1[15:8], CMT_SEC_TOP);
    min_step = bcd_inc(cnt2[7:0], CMT_SEC_TOP);
    hour_step = bcd_inc(cnt2[15:8], CMT_HOUR_TOP);
    if (tod_on && counter1_tick) begin
      if (cnt1[3:0] >= pre_top) begin
        next_cnt1[3:0] = 4'h0;
        next_cnt1[7:4] = tenth_step[3:0];
        if (tenth_step[8]) begin
          next_cnt1[15:8] = sec_step[7:0];
          if (sec_step[8]) begin
            next_cnt2[7:0] = min_step[7:0];
            if (min_step[8]) begin
              next_cnt2[15:8] = hour_step[7:0];
            end
          end
        end
      end else begin
        next_cnt1[3:0] = cnt1[3:0] + 4'h1;
      end
    end
    // A host write wins over a count step in the same cycle.
    if (commit) begin
      unique case (addr)
        CMT_ADDR_MODE: next_mode = wval;
        CMT_ADDR_EXT: next_ext = {13'h0000, wval[2:0]};
        CMT_ADDR_ALARM1: next_alarm1 = wval;
        CMT_ADDR_ALARM2: next_alarm2 = wval;
        CMT_ADDR_CNT1: next_cnt1 = wval;
        CMT_ADDR_CNT2: next_cnt2 = wval;
        default: next_mode = global_mode_control;
      endcase
    end
    unique case (addr)
      CMT_ADDR_MODE: sel_val = global_mode_control;
      CMT_ADDR_EXT: sel_val = global_mode_extension;
      CMT_ADDR_ALARM1: sel_val = alarm1;
      CMT_ADDR_ALARM2: sel_val = alarm2;
      CMT_ADDR_CNT1: sel_val = hold1;
      CMT_ADDR_CNT2: sel_val = hold2;
      default: sel_val = CMT_WORD_RST;
    endcase
    if (rd) begin
      if (addr == CMT_ADDR_STATUS) begin
        next_rdata = status;
      end else if (wide || !is_data(addr)) begin
        next_rdata = sel_val;
      end else if (ptr == CMT_PTR_LOW) begin
        next_rdata = {8'h00, sel_val[7:0]};
      end else begin
        next_rdata = {8'h00, sel_val[15:8]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      global_mode_control <= CMT_MODE_RST;
      global_mode_extension <= CMT_EXT_RST;
      alarm1 <= CMT_WORD_RST;
      alarm2 <= CMT_WORD_RST;
      cnt1 <= CMT_WORD_RST;
      cnt2 <= CMT_WORD_RST;
      hold1 <= CMT_WORD_RST;
      hold2 <= CMT_WORD_RST;
      stage <= 8'h00;
      ptr <= CMT_PTR_LOW;
      rdata <= CMT_WORD_RST;
      counter1_out <= 1'b0;
      counter2_out <= 1'b0;
    end else begin
      global_mode_control <= next_mode;
      global_mode_extension <= next_ext;
      alarm1 <= next_alarm1;
      alarm2 <= next_alarm2;
      cnt1 <= next_cnt1;
      cnt2 <= next_cnt2;
      hold1 <= next_hold1;
      hold2 <= next_hold2;
      stage <= next_stage;
      ptr <= next_ptr;
      rdata <= next_rdata;
      counter1_out <= next_c1_out;
      counter2_out <= next_c2_out;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_lo_mode_write;
    wr && addr == CMT_ADDR_MODE && !wide && !global_mode_control[CMT_MODE_POINT] &&
      ptr == CMT_PTR_LOW;
  endsequence
  sequence s_hi_mode_write;
    wr && addr == CMT_ADDR_MODE;
  endsequence

  a_status_layout: assert property ((rd && addr == CMT_ADDR_STATUS) |=>
    rdata[0] == ($past(ptr) == CMT_PTR_HIGH) && rdata[5:3] == $past(counter_out_raw[4:2]))
    else $error("status low byte does not show pointer and outputs");
  a_status_upper: assert property ((rd && addr == CMT_ADDR_STATUS) |=>
    rdata[15:14] == 2'b00 && rdata[12:8] == $past(counter_irq_state))
    else $error("status upper bits wrong");
  a_byte_pair: assert property (s_lo_mode_write ##1 s_hi_mode_write |=>
    global_mode_control == {$past(wdata[7:0]), $past(wdata[7:0], 2)})
    else $error("byte-wide mode write did not pair low then high");
  a_ptr_frozen: assert property ((global_mode_control[CMT_MODE_POINT] &&
    !(wr && addr == CMT_ADDR_CMD)) |=> $stable(ptr))
    else $error("pointer moved without a command");
  a_alarm_drive: assert property ((alarm1_enable && cnt1 == alarm1 && !commit) |=>
    counter1_out)
    else $error("counter one output not asserted on alarm match");
  a_alarm_off: assert property ((alarm_enable_field == 2'b00) |=>
    counter1_out == $past(counter_out_raw[0]) && counter2_out == $past(counter_out_raw[1]))
    else $error("disabled comparators still steer outputs");
  a_both_match: assert property ((tod_on && alarm2_enable && cnt1 != alarm1) |=>
    !counter2_out)
    else $error("counter two alarm asserted without comparator one");
  a_tenth_wrap: assert property ((tod_on && counter1_tick && !commit &&
    cnt1[3:0] >= pre_top && cnt1[7:4] == 4'h9) |=> cnt1[7:4] == 4'h0 && cnt1[3:0] == 4'h0)
    else $error("tenths did not wrap to zero");
  a_hour_wrap: assert property ((tod_on && counter1_tick && !commit &&
    cnt1[3:0] >= pre_top && cnt1[7:4] == 4'h9 && cnt1[15:8] == 8'h59 &&
    cnt2 == 16'h2359) |=> cnt2 == 16'h0000)
    else $error("clock did not roll from 23:59 to 00:00");
  a_gate_low: assert property (global_mode_control[CMT_MODE_GATE] [*2] |=>
    !freq_out)
    else $error("frequency output not held low while gated off");

endmodule : cmt_top
`default_nettype wire
